// ===== hdl/card_link_pkg.sv
// Shared constants and types for the card identification and relay shift link.
// Assumes a 100 MHz system clock and a backplane clock driven by the mainframe.
package card_link_pkg;

   // System clock rate in kHz, used to turn times into cycle counts.
   localparam int unsigned CLK_KHZ = 100000;

   // Power-up hold-off time in milliseconds.
   localparam int unsigned HOLDOFF_MS = 470;

   // Hold-off as a count of system clock cycles.
   localparam int unsigned HOLDOFF_CYCLES = HOLDOFF_MS * CLK_KHZ;

   // Width of the hold-off counter.
   localparam int unsigned HOLDOFF_W = 26;

   // Width of the identification memory address counter.
   localparam int unsigned ADDR_W = 9;

   // Bits in one serial byte.
   localparam int unsigned BYTE_W = 8;

   // Number of shift-latch registers in the relay chain.
   localparam int unsigned CHAIN_REGS = 12;

   // Number of relay bits held by the chain.
   localparam int unsigned RELAY_BITS = CHAIN_REGS * BYTE_W;

   // Bytes the mainframe shifts in for one relay update.
   localparam int unsigned RELAY_BYTES = 16;

   // Bytes read out during identification.
   localparam int unsigned ID_BYTES = 498;

   // Image layout: identifier, settling time, then the crosspoint table.
   localparam logic [ADDR_W-1:0] IMG_CARD_ID = 9'h001;
   localparam logic [ADDR_W-1:0] IMG_SETTLE = 9'h002;
   localparam logic [ADDR_W-1:0] IMG_TABLE = 9'h003;

   // Crosspoint entries in the table, one per relay.
   localparam logic [ADDR_W-1:0] IMG_TABLE_LEN = 9'h060;

   // Value of every unused image byte, and of location zero.
   localparam logic [BYTE_W-1:0] IMG_BLANK = 8'h00;

   // Index of the bit shifted out first.
   localparam int unsigned MSB = BYTE_W - 1;

   // Index of each backplane input within the synchroniser vector.
   localparam int unsigned PIN_SELECT_N = 0;
   localparam int unsigned PIN_CLEAR = 1;
   localparam int unsigned PIN_ADVANCE_N = 2;
   localparam int unsigned PIN_STROBE = 3;
   localparam int unsigned PIN_LINK_CLK = 4;
   localparam int unsigned PIN_COUNT = 5;

   // Idle level of each backplane input after reset.
   localparam logic [PIN_COUNT-1:0] PIN_IDLE = 5'h05;

   // Relay driver level for a de-energised relay.
   localparam logic [RELAY_BITS-1:0] DRIVE_OFF = {RELAY_BITS{1'b1}};

   // Serial identification pin as output level and output enable.
   typedef struct packed
   {
      logic data;
      logic oe;
   } serial_pin_type;

   // Power-up safeguard states, Gray coded along the usual path.
   typedef enum logic [1:0]
   {
      SG_HOLDOFF = 2'b00,
      SG_ARMED = 2'b01,
      SG_ENABLED = 2'b11
   } safeguard_type;

endpackage : card_link_pkg

// ===== hdl/card_id_relay_link.sv
// Card-side logic: identification readout serializer and relay shift-latch chain.
// Assumes the mainframe drives select, clear, advance, strobe, relay data and the link clock.
`timescale 1ns/1ns

// Function
// - Clear pulse zeroes the address counter.
// - Advance falling increments counter, enables loading.
// - Serializer loads continuously while advance low, from the cycle after its fall.
// - First byte sent is location one.
// - Eight bits shift out per loaded byte.
// - Image holds identifier, settling time, crosspoint table.
// - Sixteen relay bytes shift into twelve registers.
// - Each register overflows into the next.
// - Strobe transfers shifted contents to relay outputs.
// - Driver low energises relay, high releases.
// - Safeguard stays low throughout power-up.
// - Outputs disabled until first strobe enables them.
// - Strobes ignored during 470 ms hold-off.
module card_id_relay_link
#(
   // Hold-off length in system clock cycles; shorten for simulation.
   parameter int unsigned HOLDOFF_CYCLES = card_link_pkg::HOLDOFF_CYCLES,
   // Card identifier placed at image location one; the value is arbitrary.
   parameter logic [7:0] CARD_ID = 8'h5a,
   // Hardware settling time in milliseconds placed at location two.
   parameter logic [7:0] SETTLE_MS = 8'h03
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic card_select_n,
   input wire logic address_counter_clear,
   input wire logic address_advance_n,
   input wire logic relay_strobe,
   input wire logic relay_serial_in,
   output logic identity_serial_out,
   output logic identity_serial_oe,
   output logic safeguard_release,
   output logic [card_link_pkg::RELAY_BITS-1:0] relay_drive_n
);

   // Returns the identification image byte held at one address.
   function automatic logic [card_link_pkg::BYTE_W-1:0] image_byte
   (
      input logic [card_link_pkg::ADDR_W-1:0] addr
   );
      logic [card_link_pkg::ADDR_W-1:0] offset;
      offset = addr - card_link_pkg::IMG_TABLE;
      if (addr == card_link_pkg::IMG_CARD_ID)
      begin
         image_byte = CARD_ID;
      end
      else if (addr == card_link_pkg::IMG_SETTLE)
      begin
         image_byte = SETTLE_MS;
      end
      else if (addr >= card_link_pkg::IMG_TABLE && offset < card_link_pkg::IMG_TABLE_LEN)
      begin
         // Each crosspoint maps to the chain bit of the one relay it closes.
         image_byte = offset[card_link_pkg::BYTE_W-1:0];
      end
      else
      begin
         image_byte = card_link_pkg::IMG_BLANK;
      end
   endfunction : image_byte

   // Three-stage synchronisers for every backplane input sampled on clk.
   logic [card_link_pkg::PIN_COUNT-1:0] pin_s1_reg;
   logic [card_link_pkg::PIN_COUNT-1:0] pin_s2_reg;
   logic [card_link_pkg::PIN_COUNT-1:0] pin_s3_reg;
   // Filtered levels, updated only when stages two and three agree.
   logic [card_link_pkg::PIN_COUNT-1:0] pin_level_reg;
   // Filtered levels one cycle earlier, for edge detection.
   logic [card_link_pkg::PIN_COUNT-1:0] pin_prev_reg;
   // Raw pin vector in synchroniser order.
   logic [card_link_pkg::PIN_COUNT-1:0] pin_raw;
   // Edge and level terms derived from the filtered inputs.
   logic advance_fall;
   logic advance_low;
   logic clear_high;
   logic strobe_rise;
   logic link_clk_fall;
   // Identification address counter.
   logic [card_link_pkg::ADDR_W-1:0] addr_reg;
   // Identification serializer and its pin.
   logic [card_link_pkg::BYTE_W-1:0] id_shift_reg;
   card_link_pkg::serial_pin_type id_pin_reg;
   // Relay shift chain, one byte per register, clocked by the link.
   logic [card_link_pkg::BYTE_W-1:0] chain_reg [card_link_pkg::CHAIN_REGS];
   // Chain contents flattened, register zero in the low byte.
   logic [card_link_pkg::RELAY_BITS-1:0] chain_flat;
   // Pattern latched by the last accepted strobe.
   logic [card_link_pkg::RELAY_BITS-1:0] latch_reg;
   // Power-up safeguard state and hold-off counter.
   card_link_pkg::safeguard_type sg_reg;
   logic [card_link_pkg::HOLDOFF_W-1:0] holdoff_reg;
   // Relay driver outputs, active low.
   logic [card_link_pkg::RELAY_BITS-1:0] drive_n_reg;

   // Gathers the backplane pins in synchroniser order.
   always_comb
   begin
      pin_raw = '0;
      pin_raw[card_link_pkg::PIN_SELECT_N] = card_select_n;
      pin_raw[card_link_pkg::PIN_CLEAR] = address_counter_clear;
      pin_raw[card_link_pkg::PIN_ADVANCE_N] = address_advance_n;
      pin_raw[card_link_pkg::PIN_STROBE] = relay_strobe;
      pin_raw[card_link_pkg::PIN_LINK_CLK] = link_clk;
   end

   // Synchroniser chain; stage one feeds only stage two.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_reg <= card_link_pkg::PIN_IDLE;
         pin_s2_reg <= card_link_pkg::PIN_IDLE;
         pin_s3_reg <= card_link_pkg::PIN_IDLE;
      end
      else
      begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   // A pin change counts once stages two and three agree on it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_level_reg <= card_link_pkg::PIN_IDLE;
         pin_prev_reg <= card_link_pkg::PIN_IDLE;
      end
      else
      begin
         pin_level_reg <= (pin_s2_reg & pin_s3_reg) | (pin_level_reg & (pin_s2_reg | pin_s3_reg));
         pin_prev_reg <= pin_level_reg;
      end
   end

   // Edge and level terms used by the readout and safeguard logic.
   always_comb
   begin
      advance_low = !pin_level_reg[card_link_pkg::PIN_ADVANCE_N];
      advance_fall = advance_low && pin_prev_reg[card_link_pkg::PIN_ADVANCE_N];
      clear_high = pin_level_reg[card_link_pkg::PIN_CLEAR];
      strobe_rise = pin_level_reg[card_link_pkg::PIN_STROBE] && !pin_prev_reg[card_link_pkg::PIN_STROBE];
      link_clk_fall = !pin_level_reg[card_link_pkg::PIN_LINK_CLK] && pin_prev_reg[card_link_pkg::PIN_LINK_CLK];
   end

   // Address counter: cleared by the clear pulse, stepped on each advance fall.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         addr_reg <= '0;
      end
      else if (clear_high)
      begin
         // Clear wins; the next advance then selects location one.
         addr_reg <= '0;
      end
      else if (advance_fall)
      begin
         addr_reg <= addr_reg + 1'b1;
      end
   end

   // Serializer: loads every cycle while advance is low except the cycle of its fall, else shifts MSB first.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         id_shift_reg <= card_link_pkg::IMG_BLANK;
      end
      else if (advance_low && !advance_fall)
      begin
         // The load follows the stepped address, so location zero is never sent.
         id_shift_reg <= image_byte(addr_reg);
      end
      else if (link_clk_fall)
      begin
         // Mainframe samples on the rising edge; next bit moves up on the falling one.
         id_shift_reg <= {id_shift_reg[card_link_pkg::MSB-1:0], 1'b0};
      end
   end

   // Identification pin driven only while the card is selected.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         id_pin_reg <= '0;
      end
      else
      begin
         id_pin_reg.data <= id_shift_reg[card_link_pkg::MSB];
         id_pin_reg.oe <= !pin_level_reg[card_link_pkg::PIN_SELECT_N];
      end
   end

   // Relay chain in the link domain; each register overflows into the next.
   generate
      for (genvar i = 0; i < card_link_pkg::CHAIN_REGS; i++)
      begin : g_chain
         // Serial input of this register: the link pin or the previous overflow.
         logic chain_in;
         if (i == 0)
         begin : g_head
            assign chain_in = relay_serial_in;
         end
         else
         begin : g_link
            assign chain_in = chain_reg[i-1][card_link_pkg::MSB];
         end
         // One bit per link clock, entering at bit zero so the first bit ends deepest.
         always_ff @(posedge link_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               chain_reg[i] <= '0;
            end
            else
            begin
               chain_reg[i] <= {chain_reg[i][card_link_pkg::MSB-1:0], chain_in};
            end
         end
         assign chain_flat[i*card_link_pkg::BYTE_W +: card_link_pkg::BYTE_W] = chain_reg[i];
      end
   endgenerate

   // Latch captures the chain on an accepted strobe; the chain is quiet then.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latch_reg <= '0;
      end
      else if (strobe_rise)
      begin
         // The link clock stands still while the strobe is high, so the word is stable.
         latch_reg <= chain_flat;
      end
   end

   // Hold-off counter runs once from reset release.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         holdoff_reg <= '0;
      end
      else if (sg_reg == card_link_pkg::SG_HOLDOFF)
      begin
         holdoff_reg <= holdoff_reg + 1'b1;
      end
   end

   // Safeguard state: hold-off, then armed, then enabled by the first strobe.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sg_reg <= card_link_pkg::SG_HOLDOFF;
      end
      else
      begin
         unique case (sg_reg)
            card_link_pkg::SG_HOLDOFF:
            begin
               // Strobes during hold-off cannot enable the outputs.
               if (holdoff_reg == HOLDOFF_W_CAST(HOLDOFF_CYCLES - 1))
               begin
                  sg_reg <= card_link_pkg::SG_ARMED;
               end
            end
            card_link_pkg::SG_ARMED:
            begin
               if (strobe_rise)
               begin
                  sg_reg <= card_link_pkg::SG_ENABLED;
               end
            end
            card_link_pkg::SG_ENABLED:
            begin
               // Stays enabled until the next reset.
               sg_reg <= card_link_pkg::SG_ENABLED;
            end
            default:
            begin
               // An illegal code falls back to the safe state.
               sg_reg <= card_link_pkg::SG_HOLDOFF;
            end
         endcase
      end
   end

   // Drivers: low energises a relay, all high while the safeguard holds.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         drive_n_reg <= card_link_pkg::DRIVE_OFF;
      end
      else if (sg_reg == card_link_pkg::SG_ENABLED)
      begin
         drive_n_reg <= ~latch_reg;
      end
      else
      begin
         drive_n_reg <= card_link_pkg::DRIVE_OFF;
      end
   end

   // Casts the cycle count to the counter width.
   function automatic logic [card_link_pkg::HOLDOFF_W-1:0] HOLDOFF_W_CAST
   (
      input int unsigned value
   );
      HOLDOFF_W_CAST = value[card_link_pkg::HOLDOFF_W-1:0];
   endfunction : HOLDOFF_W_CAST

   // Output pins, each straight from a flip-flop.
   assign identity_serial_out = id_pin_reg.data;
   assign identity_serial_oe = id_pin_reg.oe;
   assign safeguard_release = sg_reg[1]; // Bit one of the state flop is set only once enabled.
   assign relay_drive_n = drive_n_reg;

endmodule : card_id_relay_link

// ===== hdl/unused_placeholder_never.sv
// Spare design file with no logic of its own; all card link logic is in card_id_relay_link.sv.
// Assumes nothing of its surroundings.

// ===== verif/card_link_asserts.sv
// Port-level checks of the card link.
// Assumes it is bound into card_id_relay_link.
`timescale 1ns/1ns
module card_link_asserts
#(
   parameter int unsigned HOLDOFF_CYCLES = 50
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic card_select_n,
   input wire logic address_counter_clear,
   input wire logic address_advance_n,
   input wire logic relay_strobe,
   input wire logic identity_serial_out,
   input wire logic identity_serial_oe,
   input wire logic safeguard_release,
   input wire logic [card_link_pkg::RELAY_BITS-1:0] relay_drive_n
);
   int unsigned up_cnt; // Cycles since reset.
   int unsigned strobe_age; // Cycles since strobe was high.
   int unsigned act_age; // Cycles since a load, clear, select change or link fall.
   logic link_reg; // Link clock seen one cycle ago.
   logic sel_reg; // Select seen one cycle ago.
   // Ages saturate at 99 so they never wrap.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         up_cnt <= 0;
         strobe_age <= 99;
         act_age <= 99;
         link_reg <= 1'b0;
         sel_reg <= 1'b1;
      end
      else
      begin
         link_reg <= link_clk;
         sel_reg <= card_select_n;
         up_cnt <= up_cnt + 1;
         strobe_age <= relay_strobe ? 0 : (strobe_age < 99 ? strobe_age + 1 : 99);
         if (!address_advance_n || address_counter_clear || (link_reg && !link_clk) || sel_reg != card_select_n)
            act_age <= 0;
         else
            act_age <= act_age < 99 ? act_age + 1 : 99;
      end
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_reset_idle:
      assert property ($rose(rst_n) |-> !safeguard_release && relay_drive_n == card_link_pkg::DRIVE_OFF)
      else $error("outputs active after reset");
   a_locked_off:
      assert property (!safeguard_release |-> relay_drive_n == card_link_pkg::DRIVE_OFF)
      else $error("relay energised while locked");
   a_release_sticky:
      assert property (safeguard_release |=> safeguard_release)
      else $error("safeguard dropped");
   a_release_cause:
      assert property ($rose(safeguard_release) |-> strobe_age <= 8)
      else $error("release without strobe");
   a_holdoff_guard:
      assert property (safeguard_release |-> up_cnt >= HOLDOFF_CYCLES - 1)
      else $error("release inside hold-off");
   a_drive_on_strobe:
      assert property ($changed(relay_drive_n) |-> strobe_age <= 8)
      else $error("drives changed without strobe");
   a_oe_on:
      assert property (!card_select_n [*8] |-> identity_serial_oe)
      else $error("id line not driven");
   a_oe_off:
      assert property (card_select_n [*8] |-> !identity_serial_oe)
      else $error("id line driven unselected");
   a_out_cause:
      assert property ($changed(identity_serial_out) |-> act_age <= 10)
      else $error("id bit changed with no cause");
   a_load_steady:
      assert property (!address_advance_n [*8] |=> $stable(identity_serial_out))
      else $error("id output moved during load");
endmodule : card_link_asserts

// ===== verif/mainframe_model.sv
// Mainframe side of the backplane: link clock, select, clear, advance, strobe, relay data.
// Assumes the card sees each pin a few system clocks late; link clock idles low outside frames.
`timescale 1ns/1ns
module mainframe_model
(
   input wire logic clk,
   input wire logic identity_serial_out,
   output logic link_clk,
   output logic card_select_n,
   output logic address_counter_clear,
   output logic address_advance_n,
   output logic relay_strobe,
   output logic relay_serial_in
);
   // Idle backplane levels from time zero.
   initial
   begin
      link_clk = 1'b0;
      card_select_n = 1'b1;
      address_counter_clear = 1'b0;
      address_advance_n = 1'b1;
      relay_strobe = 1'b0;
      relay_serial_in = 1'b0;
   end
   // Select level, changed at a falling system clock edge.
   task automatic select(input logic v);
      @(negedge clk);
      card_select_n = v;
   endtask : select
   // Clear pulse, four cycles wide, with quiet time after it.
   task automatic clear();
      @(negedge clk);
      address_counter_clear = 1'b1;
      repeat (4) @(negedge clk);
      address_counter_clear = 1'b0;
      repeat (4) @(negedge clk);
   endtask : clear
   // Strobe pulse; no link edges occur while it is high.
   task automatic strobe();
      @(negedge clk);
      relay_strobe = 1'b1;
      repeat (4) @(negedge clk);
      relay_strobe = 1'b0;
   endtask : strobe
   // One relay bit per link period; data moves a quarter period away from each rising edge.
   // After the bit is taken the line shows the inverse, so a late sample would be caught.
   task automatic shift_bit(input logic b);
      #16 relay_serial_in = b;
      #16 link_clk = 1'b1;
      #16 relay_serial_in = ~b;
      #16 link_clk = 1'b0;
   endtask : shift_bit
   // Advance, load, then eight bits MSB first. The card's bit lags a link fall
   // by several system clocks, so each bit is taken at the rise after the next fall.
   task automatic read_byte(output logic [7:0] b);
      @(negedge clk);
      address_advance_n = 1'b0;
      repeat (10) @(negedge clk);
      address_advance_n = 1'b1;
      repeat (6) @(negedge clk);
      #32 link_clk = 1'b1;
      for (int i = 7; i >= 0; i--)
      begin
         #32 link_clk = 1'b0;
         #32 link_clk = 1'b1;
         b[i] = identity_serial_out;
      end
      #32 link_clk = 1'b0;
   endtask : read_byte
endmodule : mainframe_model

// ===== verif/tb.sv
// Self-checking bench for the card identification and relay shift link.
// Assumes the mainframe model drives every backplane pin of the card.
`timescale 1ns/1ns
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
   $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb;
   localparam int unsigned HOLD = 400;
   localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identifier value.
   localparam logic [7:0] SETTLE_VAL = 8'h07;
   logic clk;
   logic rst_n;
   logic link_clk;
   logic card_select_n;
   logic address_counter_clear;
   logic address_advance_n;
   logic relay_strobe;
   logic relay_serial_in;
   logic identity_serial_out;
   logic identity_serial_oe;
   logic safeguard_release;
   logic [card_link_pkg::RELAY_BITS-1:0] relay_drive_n;
   int fails = 0;
   int comparisons = 0;
   logic [31:0] seed = 32'h0000_3e88; // Random state.
   bit q[$]; // Every relay bit sent, oldest first.
   logic [card_link_pkg::RELAY_BITS-1:0] exp_drive;
   logic [7:0] got_byte;
   bit again = 1'b0;
   card_id_relay_link #(.HOLDOFF_CYCLES(HOLD), .CARD_ID(ID_VAL), .SETTLE_MS(SETTLE_VAL)) card_id_relay_link_inst
   (
      .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .card_select_n(card_select_n),
      .address_counter_clear(address_counter_clear), .address_advance_n(address_advance_n),
      .relay_strobe(relay_strobe), .relay_serial_in(relay_serial_in),
      .identity_serial_out(identity_serial_out), .identity_serial_oe(identity_serial_oe),
      .safeguard_release(safeguard_release), .relay_drive_n(relay_drive_n)
   );
   mainframe_model mainframe_model_inst
   (
      .clk(clk), .identity_serial_out(identity_serial_out), .link_clk(link_clk),
      .card_select_n(card_select_n), .address_counter_clear(address_counter_clear),
      .address_advance_n(address_advance_n), .relay_strobe(relay_strobe), .relay_serial_in(relay_serial_in)
   );
   // Next xorshift value.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Expected image byte at a location.
   function automatic logic [7:0] img(input int a);
      if (a == 1)
         return ID_VAL;
      if (a == 2)
         return SETTLE_VAL;
      if (a < card_link_pkg::IMG_TABLE + card_link_pkg::IMG_TABLE_LEN)
         return 8'(a - 3);
      return card_link_pkg::IMG_BLANK;
   endfunction : img
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // System clock, 100 MHz.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cuts a hang short.
   initial
   begin
      #1000000;
      fails++;
      end_of_test();
   end
   // Main sequence.
   initial
   begin
      rst_n = 1'b0;
      exp_drive = card_link_pkg::DRIVE_OFF;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `CHK(safeguard_release, 1'b0)
      `CHK(relay_drive_n, exp_drive)
      // A strobe inside the hold-off must not enable the drives.
      mainframe_model_inst.strobe();
      repeat (10) @(negedge clk);
      `CHK(safeguard_release, 1'b0)
      `CHK(relay_drive_n, exp_drive)
      repeat (HOLD) @(negedge clk);
      // Two random frames; drives hold the old pattern until each strobe.
      for (int f = 0; f < 2; f++)
      begin
         for (int i = 0; i < 8 * card_link_pkg::RELAY_BYTES; i++)
         begin
            seed = xs(seed);
            q.push_back(seed[0]);
            mainframe_model_inst.shift_bit(seed[0]);
         end
         `CHK(relay_drive_n, exp_drive)
         mainframe_model_inst.strobe();
         repeat (8) @(negedge clk);
         for (int k = 0; k < card_link_pkg::RELAY_BITS; k++)
            exp_drive[k] = ~q[q.size() - 1 - k];
         `CHK(safeguard_release, 1'b1)
         `CHK(relay_drive_n, exp_drive)
      end
      // Identification readout, restarted once by a second clear.
      mainframe_model_inst.select(1'b0);
      repeat (8) @(negedge clk);
      `CHK(identity_serial_oe, 1'b1)
      mainframe_model_inst.clear();
      for (int a = 1; a <= card_link_pkg::ID_BYTES; a++)
      begin
         mainframe_model_inst.read_byte(got_byte);
         `CHK(got_byte, img(a))
         if (a == 3 && !again)
         begin
            again = 1'b1;
            mainframe_model_inst.clear();
            a = 0;
         end
      end
      mainframe_model_inst.select(1'b1);
      repeat (8) @(negedge clk);
      `CHK(identity_serial_oe, 1'b0)
      end_of_test();
   end
endmodule : tb
bind card_id_relay_link card_link_asserts #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) card_link_asserts_inst
(
   .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .card_select_n(card_select_n),
   .address_counter_clear(address_counter_clear), .address_advance_n(address_advance_n),
   .relay_strobe(relay_strobe), .identity_serial_out(identity_serial_out),
   .identity_serial_oe(identity_serial_oe), .safeguard_release(safeguard_release),
   .relay_drive_n(relay_drive_n)
);
